/* logic/dcp_params.svh */
// Constants for the disk controller phase and status host port.
// Assumes inclusion by the main module only.
`ifndef DCP_PARAMS_SVH
`define DCP_PARAMS_SVH
// Address select on the port pin
`define DCP_SEL_MSR        1'b0
`define DCP_SEL_DATA       1'b1
// Main status bit positions
`define DCP_MSR_RQM        7
`define DCP_MSR_DIO        6
`define DCP_MSR_NDM        5
`define DCP_MSR_BUSY       4
// Result status two bit positions
`define DCP_ST2_CTRL_MARK  6
`define DCP_ST2_CRC_DATA   5
`define DCP_ST2_WRONG_TRK  4
`define DCP_ST2_SCAN_EQ    3
`define DCP_ST2_SCAN_NOT   2
`define DCP_ST2_BAD_TRK    1
`define DCP_ST2_NO_DAM     0
// Result status one bits patched from data field errors
`define DCP_ST1_CRC        5
`define DCP_ST1_MAM        0
// Drive sense status bit positions
`define DCP_ST3_WPROT      6
`define DCP_ST3_ONE        5
`define DCP_ST3_TRK0       4
`define DCP_ST3_HEAD       2
// Reset values and fixed codes
`define DCP_ST2_RESET      8'h00
`define DCP_ST3_RESET      8'h20
`define DCP_INVALID_RESULT 8'h80
`define DCP_BAD_TRACK_NUM  8'hFF
`endif

/* logic/dcp_pkg.sv */
// Types shared by the disk controller host port files.
// Uses no macros, so dcp_params.svh is not needed here.
package dcp_pkg;
  typedef logic [7:0] dcp_byte_t;            // One data byte
  typedef enum logic [3:0] {
    PH_CMD  = 4'b0001,                       // Taking command bytes
    PH_CHK  = 4'b0010,                       // Checking the opcode
    PH_EXEC = 4'b0100,                       // Execution phase
    PH_RES  = 4'b1000                        // Result phase
  } dcp_phase_e;
  typedef struct packed {
    logic       cs_n;                        // Chip select, low active
    logic       a0;                          // Data register or main status
    logic       rd_n;                        // Read strobe
    logic       wr_n;                        // Write strobe
    logic       dma_acknowledge_n;           // DMA acknowledge
    logic       terminal_count;              // DMA terminal count
    dcp_byte_t  data;                        // Data bus in
    logic [3:0] wprot_pin;                   // Write protect level per drive
    logic [3:0] trk0_pin;                    // Track zero level per drive
  } dcp_pins_s;
  typedef struct packed {
    logic       mark_evt;                    // Data address mark examined
    logic       mark_deleted;                // That mark was deleted
    logic       rd_deleted_cmd;              // Command reads deleted data
    logic       crc_data_evt;                // CRC failure in data field
    logic       miss_evt;                    // Wanted sector not found
    dcp_byte_t  rec_track;                   // Track number read from disk
    dcp_byte_t  track_reg;                   // Stored track register
    logic       scan_eq_evt;                 // Scan equal condition met
    logic       scan_not_evt;                // Scan never satisfied
    logic       no_dam_evt;                  // No data address mark
  } dcp_evt_s;
endpackage : dcp_pkg

/* logic/dcp_buf.sv */
// Small buffer with valid and ready on both sides.
// Assumes one clock; flags come from flops so callers may export them.
`timescale 1ns/1ps
module dcp_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];             // Storage words
  logic [AW-1:0]    wp, rp, next_wp, next_rp;  // Pointers
  logic [AW:0]      cnt, next_cnt;           // Fill level
  logic             push, pop;

  // Next pointers and registered flags; a stalled reader really fills it
  always_comb begin
    push     = in_valid & in_ready;
    pop      = out_valid & out_ready;
    next_wp  = push ? ((wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1) : wp;
    next_rp  = pop ? ((rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1) : rp;
    next_cnt = cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp        <= '0;
      rp        <= '0;
      cnt       <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      wp        <= next_wp;
      rp        <= next_rp;
      cnt       <= next_cnt;
      in_ready  <= (next_cnt != (AW + 1)'(DEPTH));
      out_valid <= (next_cnt != '0);
      out_data  <= (next_cnt == '0) ? out_data : (push && cnt == pop) ? in_data : mem[next_rp];
    end
  end

  // Storage has no reset, only data lives there
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  no_overfill_a : assert property (@(posedge clk) disable iff (!rstn) cnt <= (AW + 1)'(DEPTH))
    else $error("buffer level above depth");
endmodule : dcp_buf

/* logic/dcp_host_port.sv */
// Host port of the disk controller: phases, main status, data movement,
// result status two and drive sense status.
// Assumes the disk core sits on the same clock and answers combinationally.
`timescale 1ns/1ps
`include "dcp_params.svh"
module dcp_host_port (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire dcp_pkg::dcp_pins_s pins,            // Host and drive pins
  output logic [7:0]             data_out,         // Data bus out
  output logic                   data_oe,          // High while driving bus
  output logic                   intr,             // Interrupt request
  output logic                   drq,              // DMA request
  input  wire logic [1:0]        drive_sel,        // From drive control register
  input  wire logic              dma_gate_en,      // DMA signals enabled there
  input  wire logic              spec_dma_mode,    // DMA mode from specify
  output logic [7:0]             cmd_opcode,       // First command byte
  output logic [7:0]             cmd_byte,         // Latest command byte
  output logic                   cmd_valid,        // Pulse per command byte
  input  wire logic [3:0]        core_cmd_len,     // Bytes for opcode, 0 invalid
  input  wire logic              core_sense_cmd,   // Opcode is sense drive status
  output logic                   exec_start,       // Pulse: execution begins
  input  wire logic              exec_dir_rd,      // Execution moves data to host
  input  wire logic              core_rd_valid,    // Core offers a byte
  input  wire logic [7:0]        core_rd_data,
  output logic                   core_rd_ready,
  output logic                   core_wr_valid,    // Host byte for the core
  output logic [7:0]             core_wr_data,
  input  wire logic              core_wr_ready,
  input  wire logic              core_exec_done,   // Last byte moved
  output logic                   exec_tc,          // High the cycle after terminal count is seen with acknowledge in execution phase
  input  wire dcp_pkg::dcp_evt_s evt,              // Disk side events
  input  wire logic [3:0]        core_res_len,     // Result bytes to read
  input  wire logic [7:0]        core_res_byte,    // Result byte at res_idx
  output logic [3:0]             res_idx,          // Result byte index
  output logic [7:0]             result_status_two,
  output logic [7:0]             drive_sense_status
);
  import dcp_pkg::*;

  localparam int PW = $bits(dcp_pins_s);

  // Pin synchroniser: three stages, a change counts once stages two and three agree
  logic [PW-1:0] s1, s2, s3, filt, filt_d, next_filt;
  dcp_pins_s     pf, pd;                   // Filtered pins now and one cycle back
  always_comb begin
    next_filt = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);
    pf        = dcp_pins_s'(filt);
    pd        = dcp_pins_s'(filt_d);
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1     <= '1;
      s2     <= '1;
      s3     <= '1;
      filt   <= '1;
      filt_d <= '1;
    end else begin
      s1     <= pins;
      s2     <= s1;
      s3     <= s2;
      filt   <= next_filt;
      filt_d <= filt;
    end
  end

  // Strobe end detection; a transfer counts at the rising end of its strobe
  function automatic logic rise(input logic now, input logic was);
    return now & ~was;
  endfunction

  logic port_sel, dma_sel, rd_end, wr_end, dack_fall;
  always_comb begin
    port_sel  = ~pf.cs_n;
    dma_sel   = ~pf.dma_acknowledge_n;     // Chip select is not needed here
    rd_end    = rise(pf.rd_n, pd.rd_n) & (port_sel | dma_sel);
    wr_end    = rise(pf.wr_n, pd.wr_n) & (port_sel | dma_sel);
    dack_fall = ~pf.dma_acknowledge_n & pd.dma_acknowledge_n;
  end

  // Phase and byte counting state
  dcp_phase_e phase, next_phase;
  logic [3:0] cnt, next_cnt;               // Command bytes taken
  logic [3:0] next_res_idx;
  logic       invalid, next_invalid;       // Current result is the invalid code
  logic       head, next_head;             // Head from sense command
  logic [1:0] drv, next_drv;               // Drive from sense command
  logic [7:0] next_opcode, next_cmd_byte;
  logic       next_cmd_valid, next_exec_start, next_exec_tc;
  logic       dma_on, byte_ready, cmd_take, res_take, host_move, tc_end;
  logic [7:0] main_status_register, res_byte;
  logic       buf_in_ready, buf_out_valid;
  logic [7:0] buf_out_data;

  // Status helpers: main status bits and the byte the result phase shows
  always_comb begin
    dma_on     = spec_dma_mode & dma_gate_en;
    byte_ready = exec_dir_rd ? buf_out_valid : buf_in_ready;
    main_status_register        = 8'h00;
    main_status_register[`DCP_MSR_RQM]  = (phase == PH_CMD) | (phase == PH_RES) |
                         ((phase == PH_EXEC) & ~dma_on & byte_ready);
    main_status_register[`DCP_MSR_DIO]  = (phase == PH_RES) | ((phase == PH_EXEC) & exec_dir_rd);
    main_status_register[`DCP_MSR_NDM]  = (phase == PH_EXEC) & ~dma_on;
    main_status_register[`DCP_MSR_BUSY] = (phase != PH_CMD) | (cnt != 4'h0);
    // Command bytes are refused unless ready and host-to-device
    cmd_take   = wr_end & port_sel & (pf.a0 == `DCP_SEL_DATA) &
                 main_status_register[`DCP_MSR_RQM] & ~main_status_register[`DCP_MSR_DIO] & (phase == PH_CMD);
    // Result bytes advance only when ready and device-to-host
    res_take   = rd_end & port_sel & (pf.a0 == `DCP_SEL_DATA) &
                 main_status_register[`DCP_MSR_RQM] & main_status_register[`DCP_MSR_DIO] & (phase == PH_RES);
    host_move  = (phase == PH_EXEC) & (exec_dir_rd ? rd_end : wr_end) &
                 (dma_sel | (pf.a0 == `DCP_SEL_DATA));
    tc_end     = (phase == PH_EXEC) & pf.terminal_count & ~pf.dma_acknowledge_n;
    // Data field errors are folded into status one as it passes
    res_byte   = core_res_byte;
    if (invalid) begin
      res_byte = `DCP_INVALID_RESULT;
    end else if (core_sense_cmd) begin
      res_byte = drive_sense_status;
    end else if (res_idx == 4'h1) begin
      res_byte[`DCP_ST1_CRC] = core_res_byte[`DCP_ST1_CRC] | result_status_two[`DCP_ST2_CRC_DATA];
      res_byte[`DCP_ST1_MAM] = core_res_byte[`DCP_ST1_MAM] | result_status_two[`DCP_ST2_NO_DAM];
    end else if (res_idx == 4'h2) begin
      res_byte = result_status_two;
    end
  end

  // Phase sequencing
  always_comb begin
    next_phase      = phase;
    next_cnt        = cnt;
    next_res_idx    = res_idx;
    next_invalid    = invalid;
    next_head       = head;
    next_drv        = drv;
    next_opcode     = cmd_opcode;
    next_cmd_byte   = cmd_byte;
    next_cmd_valid  = 1'b0;
    next_exec_start = 1'b0;
    next_exec_tc    = 1'b0;
    case (phase)
      PH_CMD: begin
        if (cmd_take) begin
          next_cmd_byte  = pf.data;
          next_cmd_valid = 1'b1;
          next_cnt       = cnt + 4'h1;
          if (cnt == 4'h0) begin
            next_opcode = pf.data;
            next_phase  = PH_CHK;
          end else if (cnt == 4'h1) begin
            next_head = pf.data[2];
            next_drv  = pf.data[1:0];
          end
          if (cnt != 4'h0 && (cnt + 4'h1) == core_cmd_len) begin
            next_phase      = PH_EXEC;
            next_exec_start = 1'b1;
            next_cnt        = 4'h0;
          end
        end
      end
      PH_CHK: begin
        if (core_cmd_len == 4'h0) begin
          next_phase   = PH_RES;
          next_invalid = 1'b1;
          next_res_idx = 4'h0;
          next_cnt     = 4'h0;
        end else if (core_cmd_len == 4'h1) begin
          next_phase      = PH_EXEC;
          next_exec_start = 1'b1;
          next_cnt        = 4'h0;
        end else begin
          next_phase = PH_CMD;
        end
      end
      PH_EXEC: begin
        if (tc_end) begin
          next_exec_tc = 1'b1;
        end
        if (core_exec_done) begin
          next_phase   = PH_RES;
          next_res_idx = 4'h0;
        end
      end
      PH_RES: begin
        if (res_take) begin
          next_res_idx = res_idx + 4'h1;
          if (invalid || (res_idx + 4'h1) >= core_res_len) begin
            next_phase   = PH_CMD;
            next_invalid = 1'b0;
            next_res_idx = 4'h0;
          end
        end
      end
      default: begin
        next_phase = PH_CMD;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase      <= PH_CMD;
      cnt        <= 4'h0;
      res_idx    <= 4'h0;
      invalid    <= 1'b0;
      head       <= 1'b0;
      drv        <= 2'h0;
      cmd_opcode <= 8'h00;
      cmd_byte   <= 8'h00;
      cmd_valid  <= 1'b0;
      exec_start <= 1'b0;
      exec_tc    <= 1'b0;
    end else begin
      phase      <= next_phase;
      cnt        <= next_cnt;
      res_idx    <= next_res_idx;
      invalid    <= next_invalid;
      head       <= next_head;
      drv        <= next_drv;
      cmd_opcode <= next_opcode;
      cmd_byte   <= next_cmd_byte;
      cmd_valid  <= next_cmd_valid;
      exec_start <= next_exec_start;
      exec_tc    <= next_exec_tc;
    end
  end

  // Execution data buffer; a slow reader stalls the core, no byte is lost
  dcp_buf #(.WIDTH(8), .DEPTH(2)) u_buf (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (exec_dir_rd ? core_rd_valid : (host_move & ~exec_dir_rd)),
    .in_ready  (buf_in_ready),
    .in_data   (exec_dir_rd ? core_rd_data : pf.data),
    .out_valid (buf_out_valid),
    .out_ready (exec_dir_rd ? host_move : core_wr_ready),
    .out_data  (buf_out_data)
  );

  // Handshake outputs towards the core follow the buffer's registered flags
  always_comb begin
    core_rd_ready = buf_in_ready;
    core_wr_valid = buf_out_valid;
    core_wr_data  = buf_out_data;
  end

  // Interrupt and DMA request; for intr a set wins over a same-cycle clear, for drq the clear wins
  logic next_intr, next_drq, moved_d;
  logic byte_irq_set, res_irq_set;
  always_comb begin
    byte_irq_set = (phase == PH_EXEC) & ~dma_on & byte_ready & ~host_move & ~moved_d;
    res_irq_set  = (phase == PH_EXEC) & (next_phase == PH_RES);
    next_intr    = intr;
    if (host_move || (res_take && res_idx == 4'h0)) begin
      next_intr = 1'b0;
    end
    if (byte_irq_set || res_irq_set || (phase == PH_CHK && next_phase == PH_RES)) begin
      next_intr = 1'b1;
    end
    next_drq = drq;
    if (dack_fall || phase != PH_EXEC) begin
      next_drq = 1'b0;
    end else if (dma_on && byte_ready && pf.dma_acknowledge_n && !moved_d && !host_move) begin
      next_drq = 1'b1;
    end
  end

  // Bus read data comes from a register, driven only during a selected read
  logic [7:0] next_dout;
  logic       next_oe;
  always_comb begin
    next_oe   = ~pf.rd_n & (port_sel | dma_sel);
    next_dout = main_status_register;
    if (dma_sel || pf.a0 == `DCP_SEL_DATA) begin
      next_dout = (phase == PH_RES) ? res_byte : buf_out_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      intr     <= 1'b0;
      drq      <= 1'b0;
      moved_d  <= 1'b0;
      data_out <= 8'h00;
      data_oe  <= 1'b0;
    end else begin
      intr     <= next_intr;
      drq      <= next_drq;
      moved_d  <= host_move;
      data_out <= next_dout;
      data_oe  <= next_oe;
    end
  end

  // Status bytes; drive select changes act at once, the host times them
  logic [7:0] next_st2, next_st3;
  logic       trk_differs;
  logic       wp_now;                      // Write protect level of the selected drive
  always_comb begin
    trk_differs = evt.rec_track != evt.track_reg;
    wp_now      = pf.wprot_pin[drive_sel];
    next_st2    = exec_start ? `DCP_ST2_RESET : result_status_two;
    if (phase == PH_EXEC) begin
      if (evt.mark_evt && (evt.mark_deleted != evt.rd_deleted_cmd)) begin
        next_st2[`DCP_ST2_CTRL_MARK] = 1'b1;
      end
      if (evt.crc_data_evt) begin
        next_st2[`DCP_ST2_CRC_DATA] = 1'b1;
      end
      if (evt.miss_evt && trk_differs) begin
        next_st2[`DCP_ST2_WRONG_TRK] = 1'b1;
        if (evt.rec_track == `DCP_BAD_TRACK_NUM) begin
          next_st2[`DCP_ST2_BAD_TRK] = 1'b1;
        end
      end
      if (evt.scan_eq_evt) begin
        next_st2[`DCP_ST2_SCAN_EQ] = 1'b1;
      end
      if (evt.scan_not_evt) begin
        next_st2[`DCP_ST2_SCAN_NOT] = 1'b1;
      end
      if (evt.no_dam_evt) begin
        next_st2[`DCP_ST2_NO_DAM] = 1'b1;
      end
    end
    next_st3 = `DCP_ST3_RESET;
    next_st3[`DCP_ST3_WPROT] = ~pf.wprot_pin[drive_sel];
    next_st3[`DCP_ST3_TRK0]  = ~pf.trk0_pin[drive_sel];
    next_st3[`DCP_ST3_HEAD]  = head;
    next_st3[1:0]            = drv;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      result_status_two  <= `DCP_ST2_RESET;
      drive_sense_status <= `DCP_ST3_RESET;
    end else begin
      result_status_two  <= next_st2;
      drive_sense_status <= next_st3;
    end
  end

  // Checks of the sequencing and status behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  cmd_write_gate_a : assert property (cmd_take |-> main_status_register[7] && !main_status_register[6])
    else $error("command byte taken while not ready for input");
  res_read_gate_a : assert property (res_take |-> main_status_register[7] && main_status_register[6])
    else $error("result byte taken while not ready for output");
  exec_start_a : assert property (cmd_take && cnt != 4'h0 && (cnt + 4'h1) == core_cmd_len
      |=> exec_start && phase == PH_EXEC)
    else $error("execution did not start after last command byte");
  drq_gate_a : assert property ($rose(drq) |-> $past(dma_on))
    else $error("DMA request raised without DMA mode and enable");
  drq_drop_a : assert property (dack_fall |=> !drq)
    else $error("DMA request not dropped on acknowledge");
  tc_gate_a : assert property (exec_tc |-> $past(!pf.dma_acknowledge_n && pf.terminal_count))
    else $error("terminal count honoured without acknowledge");
  res_intr_a : assert property (phase == PH_EXEC && core_exec_done |=> intr && phase == PH_RES)
    else $error("no interrupt on entry to result phase");
  invalid_code_a : assert property (phase == PH_CHK && core_cmd_len == 4'h0
      |=> phase == PH_RES && res_byte == 8'h80 && intr)
    else $error("invalid opcode did not yield 80H result");
  bad_track_a : assert property (phase == PH_EXEC && evt.miss_evt && evt.rec_track == 8'hFF
      && evt.track_reg != 8'hFF |=> result_status_two[1] && result_status_two[4])
    else $error("bad track flags not set");
  sense_wp_a : assert property (##1 drive_sense_status[6] == !$past(wp_now))
    else $error("sense write protect bit wrong");

  cover_invalid_c : cover property (phase == PH_CHK && core_cmd_len == 4'h0);
  cover_dma_c : cover property ($rose(drq) ##[1:20] dack_fall);
  cover_tc_c : cover property (exec_tc);
  cover_res_c : cover property (res_take && res_idx == 4'h2);
endmodule : dcp_host_port

/* test/dcp_host_model.sv */
// Host processor model: polls main status and moves bytes on the port pins.
// Assumes a 40 MHz clk and a bench that waits out reset before calling it.
`timescale 1ns/1ps
module dcp_host_model (
  input  wire logic          clk,
  input  wire logic [7:0]    data_out,
  output dcp_pkg::dcp_pins_s pins
);
  import dcp_pkg::*;
  logic [7:0] seen;  // Byte caught at the end of the last read or write strobe
  event       got;   // A data register read has finished
  initial pins = 22'h3EFFFF;  // All strobes idle high, no terminal count
  // One strobe held 8 clk; select and data kept past its end
  task automatic cyc(input logic rd, input logic a0, input logic [7:0] d);
    @(negedge clk);
    pins.cs_n = 1'b0;
    pins.a0   = a0;
    pins.data = d;
    pins.rd_n = !rd;
    pins.wr_n = rd;
    repeat (8) @(negedge clk);
    seen = data_out;
    pins.rd_n = 1'b1;
    pins.wr_n = 1'b1;
    repeat (6) @(negedge clk);
    pins.cs_n = 1'b1;
    pins.data = ~d;  // A released bus must not keep its last value
  endtask : cyc
  // Poll main status until ready in the wanted direction, then move one byte
  task automatic xfer(input logic rd, input logic [7:0] d);
    for (int n = 0; n < 30; n++) begin
      cyc(1'b1, 1'b0, 8'h00);
      if (seen[7] && seen[6] == rd) break;
    end
    cyc(rd, 1'b1, d);
    if (rd) ->got;
  endtask : xfer
endmodule : dcp_host_model

/* test/disk_ctrl_phase_status_host_port_tb_top.sv */
// Bench for the host port: invalid opcode, sense commands, status bytes.
// Assumes the host model on the pins; the core side is driven here.
`timescale 1ns/1ps
module disk_ctrl_phase_status_host_port_tb_top;
  import dcp_pkg::*;
  logic       clk = 1'b0, rstn = 1'b0, intr, done = 1'b0;
  dcp_pins_s  pins;
  logic [7:0] data_out, st2, st3;
  logic [3:0] cmd_len = 4'h0;
  logic [1:0] sel = 2'h0;
  logic       sense = 1'b1, wr_rdy = 1'b1, dma_en = 1'b0;  // Core side levels
  logic [3:0] res_len = 4'h3;                              // Result bytes per command
  logic [7:0] res_byte = 8'h00;                            // Core result byte
  dcp_evt_s   evt = '0;
  logic [7:0] exp_q[$];  // Expected read bytes, oldest first
  int         bad_count = 0, check_count = 0;
  logic [7:0] ev[3] = '{8'h18, 8'hC4, 8'h03};  // Event flags per pass
  logic [7:0] s2[3] = '{8'h32, 8'h48, 8'h05};  // Status two per pass
  logic [7:0] s1[3] = '{8'h20, 8'h00, 8'h01};  // Result byte one per pass
  always #12.5 clk = ~clk;
  dcp_host_model u_host (.clk(clk), .data_out(data_out), .pins(pins));
  dcp_host_port u_dut (.clk(clk), .rstn(rstn), .pins(pins), .data_out(data_out), .data_oe(), .intr(intr),
    .drq(), .drive_sel(sel), .dma_gate_en(dma_en), .spec_dma_mode(1'b0), .cmd_opcode(), .cmd_byte(),
    .cmd_valid(), .core_cmd_len(cmd_len), .core_sense_cmd(sense), .exec_start(), .exec_dir_rd(1'b0),
    .core_rd_valid(1'b0), .core_rd_data(8'h00), .core_rd_ready(), .core_wr_valid(), .core_wr_data(),
    .core_wr_ready(wr_rdy), .core_exec_done(done), .exec_tc(), .evt(evt), .core_res_len(res_len),
    .core_res_byte(res_byte), .res_idx(), .result_status_two(st2), .drive_sense_status(st3));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // Each finished read is compared with the oldest note
  always @(u_host.got) chk("read byte", exp_q.pop_front(), u_host.seen);
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #1ms;
    bad_count++;
    wrap_up();
  end
  initial begin
    logic [1:0] dr;
    logic       hd;
    logic [3:0] wp, t0;
    logic [6:0] trk;
    void'($urandom(32'h185e25c6));
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    repeat (6) @(negedge clk);
    chk("status two reset", 8'h00, st2);
    chk("sense status reset", 8'h20, st3);
    u_host.xfer(1'b0, 8'hFF);
    repeat (2) @(negedge clk);
    chk("invalid intr", 8'(intr), 8'h01);
    exp_q.push_back(8'h80);
    u_host.xfer(1'b1, 8'h00);
    $display("invalid opcode test done");
    for (int i = 0; i < 3; i++) begin
      {dr, hd, wp, t0, trk} = 18'($urandom);
      sel = dr;
      u_host.pins.wprot_pin = wp;
      u_host.pins.trk0_pin = t0;
      cmd_len = 4'h2;
      u_host.xfer(1'b0, 8'h04);
      u_host.xfer(1'b0, {5'h00, hd, dr});
      repeat (4) @(negedge clk);
      evt = {ev[i][7:3], 8'hFF, 1'b0, trk, ev[i][2:0]};
      @(negedge clk);
      evt = '0;
      done = 1'b1;
      @(negedge clk);
      done = 1'b0;
      repeat (3) @(negedge clk);
      chk("result intr", 8'(intr), 8'h01);
      chk("status two", s2[i], st2);
      exp_q.push_back({1'b0, ~wp[dr], 1'b1, ~t0[dr], 1'b0, hd, dr});
      exp_q.push_back(s1[i]);
      exp_q.push_back(s2[i]);
      // The core flags the sense byte only for byte 0; bytes 1 and 2 carry the status bytes
      sense = 1'b1;
      u_host.xfer(1'b1, 8'h00);
      sense = 1'b0;
      repeat (2) u_host.xfer(1'b1, 8'h00);
      $display("sense pass %0d done", i);
    end
    wrap_up();
  end
endmodule : disk_ctrl_phase_status_host_port_tb_top
